// ==== hw/slpf_core.sv ====
// speed-loop p/pi selector, feedforward source selection and load torque compensation
// ****************************************
// Overview of operation
// RULE1 - speed regulator runs pi by default, p-only only when switch condition holds
// RULE2 - mode 0 torque, 1 deviation, 2 accel, 3 speed, 4 fixed pi; reset 0
// RULE3 - modes 0..3: p-only while quantity exceeds threshold, else pi
// RULE4 - mode 4 never selects p-only action
// RULE5 - each condition compares against its own threshold setting
// RULE6 - torque threshold defaults 200; p-only strictly above, pi at or below
// RULE7 - speed ff source: 0 internal, 1 model, 2 host, 3 cubic
// RULE8 - torque ff source uses same encoding, internal default
// RULE9 - internal speed ff is position reference derivative times speed ff gain
// RULE10 - internal torque ff is speed ref derivative times inertia times gain
// RULE11 - internal speed and torque ff low-pass filtered, each own time setting
// RULE12 - torque ff variant 0 general, 2 high-speed computation
// RULE13 - host enables model following before choosing model ff sources
// RULE14 - host sources take velocity offset and torque offset values
// RULE15 - cubic source needs canopen and cubic interpolation mode selected
// RULE16 - host-supplied sources usable only with canopen communication
// RULE17 - load compensation: observer output scaled by percentage added to torque
// RULE18 - observer gain sets observer bandwidth; larger tracks closer; code uses only gain bits 3:0, so 16 and above repeat the 0..15 response
// RULE19 - selectors latched at restart; thresholds, gains, filters apply next sample
// ****************************************
`default_nettype none
module slpf_core #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sampleTick,
  input wire slpf_pkg::slpf_loop_t loopIn,
  input wire slpf_pkg::slpf_ff_t modelFfIn,
  input wire slpf_pkg::slpf_ff_t cubicFfIn,
  output logic proportionalOnly,
  output slpf_pkg::slpf_ff_t ffOut,
  output logic signed [W-1:0] torqueRefOut
);
  // ****************************************
  // register file
  // ****************************************
  slpf_pkg::slpf_bus_t bus_q, bus_d;
  logic [31:0] dat_q, dat_d;
  logic [31:0] ctrl_q, ctrl_d;
  slpf_pkg::slpf_sel_t sel_q, sel_d;
  logic restartPend_q, restartPend_d;
  logic [15:0] trqTh_q, trqTh_d, devTh_q, devTh_d, accTh_q, accTh_d, spdTh_q, spdTh_d;
  logic [15:0] sffGain_q, sffGain_d, tffGain_q, tffGain_d, inertia_q, inertia_d;
  logic [15:0] loadComp_q, loadComp_d, obsGain_q, obsGain_d;
  logic [3:0] sffFilt_q, sffFilt_d, tffFilt_q, tffFilt_d;
  logic signed [15:0] hostVel_q, hostVel_d, hostTrq_q, hostTrq_d;
  logic wrNow;
  logic [31:0] rdMux;
  logic [31:0] wrMask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_comb begin
    wrMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    bus_d = bus_q;
    wrNow = 1'b0;
    case (bus_q)
      slpf_pkg::BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          bus_d = slpf_pkg::BUS_ACK;
        end
      end
      slpf_pkg::BUS_ACK: begin
        wrNow = wb_cyc_i && wb_stb_i && wb_we_i;
        bus_d = slpf_pkg::BUS_IDLE;
      end
      default: begin
        bus_d = slpf_pkg::BUS_IDLE;
      end
    endcase
  end

  always_comb begin
    case (wb_adr_i)
      slpf_pkg::OFS_CTRL: rdMux = ctrl_q;
      slpf_pkg::OFS_TRQ_TH: rdMux = {16'h0000, trqTh_q};
      slpf_pkg::OFS_DEV_TH: rdMux = {16'h0000, devTh_q};
      slpf_pkg::OFS_ACC_TH: rdMux = {16'h0000, accTh_q};
      slpf_pkg::OFS_SPD_TH: rdMux = {16'h0000, spdTh_q};
      slpf_pkg::OFS_SFF_GAIN: rdMux = {16'h0000, sffGain_q};
      slpf_pkg::OFS_SFF_FILT: rdMux = {28'h0000000, sffFilt_q};
      slpf_pkg::OFS_TFF_GAIN: rdMux = {16'h0000, tffGain_q};
      slpf_pkg::OFS_TFF_FILT: rdMux = {28'h0000000, tffFilt_q};
      slpf_pkg::OFS_INERTIA: rdMux = {16'h0000, inertia_q};
      slpf_pkg::OFS_LOAD_COMP: rdMux = {16'h0000, loadComp_q};
      slpf_pkg::OFS_OBS_GAIN: rdMux = {16'h0000, obsGain_q};
      slpf_pkg::OFS_HOST_VEL: rdMux = {16'h0000, hostVel_q};
      slpf_pkg::OFS_HOST_TRQ: rdMux = {16'h0000, hostTrq_q};
      slpf_pkg::OFS_STATUS: rdMux = {20'h00000, sel_q, proportionalOnly};
      slpf_pkg::OFS_SPEED_FF: rdMux = {16'h0000, ffOut.speedFf};
      slpf_pkg::OFS_TORQUE_FF: rdMux = {16'h0000, ffOut.torqueFf};
      slpf_pkg::OFS_TORQUE_OUT: rdMux = {16'h0000, torqueRefOut};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_comb begin
    dat_d = dat_q;
    if (bus_q == slpf_pkg::BUS_IDLE && wb_cyc_i && wb_stb_i) begin
      dat_d = rdMux;
    end
    ctrl_d = ctrl_q;
    trqTh_d = trqTh_q;
    devTh_d = devTh_q;
    accTh_d = accTh_q;
    spdTh_d = spdTh_q;
    sffGain_d = sffGain_q;
    sffFilt_d = sffFilt_q;
    tffGain_d = tffGain_q;
    tffFilt_d = tffFilt_q;
    inertia_d = inertia_q;
    loadComp_d = loadComp_q;
    obsGain_d = obsGain_q;
    hostVel_d = hostVel_q;
    hostTrq_d = hostTrq_q;
    restartPend_d = 1'b0;
    sel_d = sel_q;
    if (wrNow) begin
      case (wb_adr_i)
        slpf_pkg::OFS_CTRL: ctrl_d = merge(ctrl_q, wb_dat_i, wrMask) & 32'h00333337;
        slpf_pkg::OFS_CMD: restartPend_d = wb_sel_i[0] & wb_dat_i[slpf_pkg::POS_RESTART];
        slpf_pkg::OFS_TRQ_TH: trqTh_d = 16'(merge({16'h0000, trqTh_q}, wb_dat_i, wrMask)); // RULE19
        slpf_pkg::OFS_DEV_TH: devTh_d = 16'(merge({16'h0000, devTh_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_ACC_TH: accTh_d = 16'(merge({16'h0000, accTh_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_SPD_TH: spdTh_d = 16'(merge({16'h0000, spdTh_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_SFF_GAIN: sffGain_d = 16'(merge({16'h0000, sffGain_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_SFF_FILT: sffFilt_d = 4'(merge({28'h0000000, sffFilt_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_TFF_GAIN: tffGain_d = 16'(merge({16'h0000, tffGain_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_TFF_FILT: tffFilt_d = 4'(merge({28'h0000000, tffFilt_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_INERTIA: inertia_d = 16'(merge({16'h0000, inertia_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_LOAD_COMP: loadComp_d = 16'(merge({16'h0000, loadComp_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_OBS_GAIN: obsGain_d = 16'(merge({16'h0000, obsGain_q}, wb_dat_i, wrMask));
        slpf_pkg::OFS_HOST_VEL: hostVel_d = 16'(merge({16'h0000, hostVel_q}, wb_dat_i, wrMask)); // RULE14
        slpf_pkg::OFS_HOST_TRQ: hostTrq_d = 16'(merge({16'h0000, hostTrq_q}, wb_dat_i, wrMask)); // RULE14
        default: begin
        end
      endcase
    end
    // selectors take the pending control value only at restart
    if (restartPend_q) begin
      // a restart written in this cycle stays pending
      sel_d.regulatorSwitchModeSel = ctrl_q[slpf_pkg::POS_MODE +: 3]; // RULE19
      sel_d.speedFfSourceSel = ctrl_q[slpf_pkg::POS_SFF_SRC +: 2];
      sel_d.torqueFfSourceSel = ctrl_q[slpf_pkg::POS_TFF_SRC +: 2];
      sel_d.torqueFfVariantSel = ctrl_q[slpf_pkg::POS_TFF_VAR +: 2];
      sel_d.modelFollowEnable = ctrl_q[slpf_pkg::POS_MF_EN +: 2];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_q <= slpf_pkg::BUS_IDLE;
      dat_q <= 32'h00000000;
      ctrl_q <= 32'h00000000;
      sel_q <= '0; // RULE2
      restartPend_q <= 1'b0;
      trqTh_q <= slpf_pkg::RST_TRQ_TH; // RULE6
      devTh_q <= slpf_pkg::RST_ZERO;
      accTh_q <= slpf_pkg::RST_ZERO;
      spdTh_q <= slpf_pkg::RST_ZERO;
      sffGain_q <= slpf_pkg::RST_ZERO;
      sffFilt_q <= slpf_pkg::RST_FILT;
      tffGain_q <= slpf_pkg::RST_ZERO;
      tffFilt_q <= slpf_pkg::RST_FILT;
      inertia_q <= slpf_pkg::RST_INERTIA;
      loadComp_q <= slpf_pkg::RST_ZERO;
      obsGain_q <= slpf_pkg::RST_ZERO;
      hostVel_q <= slpf_pkg::RST_ZERO;
      hostTrq_q <= slpf_pkg::RST_ZERO;
    end else begin
      bus_q <= bus_d;
      dat_q <= dat_d;
      ctrl_q <= ctrl_d;
      sel_q <= sel_d;
      restartPend_q <= restartPend_d;
      trqTh_q <= trqTh_d;
      devTh_q <= devTh_d;
      accTh_q <= accTh_d;
      spdTh_q <= spdTh_d;
      sffGain_q <= sffGain_d;
      sffFilt_q <= sffFilt_d;
      tffGain_q <= tffGain_d;
      tffFilt_q <= tffFilt_d;
      inertia_q <= inertia_d;
      loadComp_q <= loadComp_d;
      obsGain_q <= obsGain_d;
      hostVel_q <= hostVel_d;
      hostTrq_q <= hostTrq_d;
    end
  end

  assign wb_ack_o = (bus_q == slpf_pkg::BUS_ACK);
  assign wb_dat_o = dat_q;

  // ****************************************
  // p/pi switching and feedforward
  // ****************************************
  logic pOnly_q, pOnly_d;
  logic signed [W-1:0] prevPos_q, prevPos_d, prevSpd_q, prevSpd_d, prevDpos_q, prevDpos_d;
  slpf_pkg::slpf_ff_t ff_q, ff_d;
  logic signed [W-1:0] trq_q, trq_d;
  logic signed [W:0] dPos, dSpd, ddPos, tffDeriv;
  logic signed [47:0] sffRaw, tffRaw, compRaw;
  logic signed [W-1:0] sffInt, tffInt, sffFilt, tffFilt, obsIn, obsEst;
  logic [15:0] absQty;
  logic [15:0] thSel;
  logic canopen, cubicSel;
  logic [3:0] obsShift;

  function automatic logic signed [W-1:0] sat(input logic signed [47:0] v);
    logic signed [47:0] hi;
    logic signed [47:0] lo;
    hi = 48'sd32767;
    lo = -48'sd32768;
    if (v > hi) begin
      sat = W'(hi);
    end else if (v < lo) begin
      sat = W'(lo);
    end else begin
      sat = W'(v);
    end
  endfunction

  function automatic logic [15:0] absv(input logic signed [W-1:0] v);
    absv = v[W-1] ? 16'(-v) : 16'(v);
  endfunction

  always_comb begin
    canopen = ctrl_q[slpf_pkg::POS_CANOPEN];
    cubicSel = ctrl_q[slpf_pkg::POS_CUBIC];
    case (sel_q.regulatorSwitchModeSel) // RULE5
      slpf_pkg::MODE_TORQUE: begin
        absQty = absv(loopIn.torqueRefPct);
        thSel = trqTh_q;
      end
      slpf_pkg::MODE_DEV: begin
        absQty = absv(loopIn.deviationCount);
        thSel = devTh_q;
      end
      slpf_pkg::MODE_ACCEL: begin
        absQty = absv(loopIn.accelRef);
        thSel = accTh_q;
      end
      slpf_pkg::MODE_SPEED: begin
        absQty = absv(loopIn.speedRef);
        thSel = spdTh_q;
      end
      default: begin
        absQty = 16'h0000;
        thSel = 16'hffff;
      end
    endcase
    dPos = {loopIn.positionRef[W-1], loopIn.positionRef} - {prevPos_q[W-1], prevPos_q};
    dSpd = {loopIn.speedRef[W-1], loopIn.speedRef} - {prevSpd_q[W-1], prevSpd_q};
    ddPos = dPos - {prevDpos_q[W-1], prevDpos_q};
    tffDeriv = (sel_q.torqueFfVariantSel == slpf_pkg::VAR_HIGH_SPEED) ? ddPos : dSpd; // RULE12
    sffRaw = (48'(dPos) * $signed({32'h00000000, sffGain_q})) / slpf_pkg::PCT; // RULE9
    tffRaw = (48'(tffDeriv) * $signed({32'h00000000, inertia_q})
      * $signed({32'h00000000, tffGain_q})) / slpf_pkg::PCT2; // RULE10
    sffInt = sat(sffRaw);
    tffInt = sat(tffRaw);
    obsIn = sat(48'(loopIn.torqueRefPct) - 48'(loopIn.actualTorque));
    obsShift = 4'hf - obsGain_q[3:0]; // RULE18
    compRaw = (48'(obsEst) * $signed({32'h00000000, loadComp_q})) / slpf_pkg::PCT;
    pOnly_d = pOnly_q;
    ff_d = ff_q;
    trq_d = trq_q;
    prevPos_d = prevPos_q;
    prevSpd_d = prevSpd_q;
    prevDpos_d = prevDpos_q;
    if (sampleTick) begin
      prevPos_d = loopIn.positionRef;
      prevSpd_d = loopIn.speedRef;
      prevDpos_d = sat(48'(dPos));
      // pi unless the selected quantity is strictly above its threshold
      pOnly_d = (sel_q.regulatorSwitchModeSel != slpf_pkg::MODE_FIXED_PI) && (absQty > thSel); // RULE1 RULE3 RULE4 RULE6
      case (sel_q.speedFfSourceSel) // RULE7
        slpf_pkg::SRC_INTERNAL: ff_d.speedFf = sffFilt; // RULE11
        slpf_pkg::SRC_MODEL: ff_d.speedFf = (sel_q.modelFollowEnable != 2'h0) ? modelFfIn.speedFf : '0; // RULE13
        slpf_pkg::SRC_HOST: ff_d.speedFf = canopen ? hostVel_q : '0; // RULE16
        slpf_pkg::SRC_CUBIC: ff_d.speedFf = (canopen && cubicSel) ? cubicFfIn.speedFf : '0; // RULE15
        default: ff_d.speedFf = '0;
      endcase
      case (sel_q.torqueFfSourceSel) // RULE8
        slpf_pkg::SRC_INTERNAL: ff_d.torqueFf = tffFilt; // RULE11
        slpf_pkg::SRC_MODEL: ff_d.torqueFf = (sel_q.modelFollowEnable != 2'h0) ? modelFfIn.torqueFf : '0;
        slpf_pkg::SRC_HOST: ff_d.torqueFf = canopen ? hostTrq_q : '0; // RULE16
        slpf_pkg::SRC_CUBIC: ff_d.torqueFf = (canopen && cubicSel) ? cubicFfIn.torqueFf : '0; // RULE15
        default: ff_d.torqueFf = '0;
      endcase
      trq_d = sat(48'(loopIn.torqueRefPct) + compRaw); // RULE17
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pOnly_q <= 1'b0;
      ff_q <= '0;
      trq_q <= '0;
      prevPos_q <= '0;
      prevSpd_q <= '0;
      prevDpos_q <= '0;
    end else begin
      pOnly_q <= pOnly_d;
      ff_q <= ff_d;
      trq_q <= trq_d;
      prevPos_q <= prevPos_d;
      prevSpd_q <= prevSpd_d;
      prevDpos_q <= prevDpos_d;
    end
  end

  slpf_lpf #(.W(W)) sffLpf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sampleTick(sampleTick),
    .filtIn(sffInt),
    .shiftAmt(sffFilt_q),
    .filtOut(sffFilt)
  );

  slpf_lpf #(.W(W)) tffLpf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sampleTick(sampleTick),
    .filtIn(tffInt),
    .shiftAmt(tffFilt_q),
    .filtOut(tffFilt)
  );

  slpf_lpf #(.W(W)) obsLpf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sampleTick(sampleTick),
    .filtIn(obsIn),
    .shiftAmt(obsShift),
    .filtOut(obsEst)
  );

  assign proportionalOnly = pOnly_q;
  assign ffOut = ff_q;
  assign torqueRefOut = trq_q;
endmodule
`default_nettype wire

// ==== hw/slpf_pkg.sv ====
// package: register map, field positions, reset values and carriers of the speed-loop selector
`default_nettype none
package slpf_pkg;
  localparam int DW = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_TRQ_TH = 8'h08;
  localparam logic [7:0] OFS_DEV_TH = 8'h0c;
  localparam logic [7:0] OFS_ACC_TH = 8'h10;
  localparam logic [7:0] OFS_SPD_TH = 8'h14;
  localparam logic [7:0] OFS_SFF_GAIN = 8'h18;
  localparam logic [7:0] OFS_SFF_FILT = 8'h1c;
  localparam logic [7:0] OFS_TFF_GAIN = 8'h20;
  localparam logic [7:0] OFS_TFF_FILT = 8'h24;
  localparam logic [7:0] OFS_INERTIA = 8'h28;
  localparam logic [7:0] OFS_LOAD_COMP = 8'h2c;
  localparam logic [7:0] OFS_OBS_GAIN = 8'h30;
  localparam logic [7:0] OFS_HOST_VEL = 8'h34;
  localparam logic [7:0] OFS_HOST_TRQ = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3c;
  localparam logic [7:0] OFS_SPEED_FF = 8'h40;
  localparam logic [7:0] OFS_TORQUE_FF = 8'h44;
  localparam logic [7:0] OFS_TORQUE_OUT = 8'h48;
  // control register field positions and command register restart bit
  localparam int POS_MODE = 0;
  localparam int POS_SFF_SRC = 4;
  localparam int POS_TFF_SRC = 8;
  localparam int POS_TFF_VAR = 12;
  localparam int POS_MF_EN = 16;
  localparam int POS_CANOPEN = 20;
  localparam int POS_CUBIC = 21;
  localparam int POS_RESTART = 0;
  // reset values
  localparam logic [15:0] RST_TRQ_TH = 16'h00c8;
  localparam logic [15:0] RST_INERTIA = 16'h0064;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [3:0] RST_FILT = 4'h0;
  // percent scaling
  localparam int PCT = 100;
  localparam int PCT2 = 10000;
  // selector encodings
  localparam logic [2:0] MODE_TORQUE = 3'h0;
  localparam logic [2:0] MODE_DEV = 3'h1;
  localparam logic [2:0] MODE_ACCEL = 3'h2;
  localparam logic [2:0] MODE_SPEED = 3'h3;
  localparam logic [2:0] MODE_FIXED_PI = 3'h4;
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_MODEL = 2'h1;
  localparam logic [1:0] SRC_HOST = 2'h2;
  localparam logic [1:0] SRC_CUBIC = 2'h3;
  localparam logic [1:0] VAR_GENERAL = 2'h0;
  localparam logic [1:0] VAR_HIGH_SPEED = 2'h2;

  typedef struct packed {
    logic [2:0] regulatorSwitchModeSel;
    logic [1:0] speedFfSourceSel;
    logic [1:0] torqueFfSourceSel;
    logic [1:0] torqueFfVariantSel;
    logic [1:0] modelFollowEnable;
  } slpf_sel_t;

  typedef struct packed {
    logic signed [DW-1:0] positionRef;
    logic signed [DW-1:0] speedRef;
    logic signed [DW-1:0] torqueRefPct;
    logic signed [DW-1:0] deviationCount;
    logic signed [DW-1:0] accelRef;
    logic signed [DW-1:0] actualTorque;
  } slpf_loop_t;

  typedef struct packed {
    logic signed [DW-1:0] speedFf;
    logic signed [DW-1:0] torqueFf;
  } slpf_ff_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } slpf_bus_t;
endpackage
`default_nettype wire

// ==== hw/slpf_lpf.sv ====
// first-order low-pass: output moves toward input by a power-of-two fraction each sample
`default_nettype none
module slpf_lpf #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sampleTick,
  input wire logic signed [W-1:0] filtIn,
  input wire logic [3:0] shiftAmt,
  output logic signed [W-1:0] filtOut
);
  logic signed [W-1:0] y_q;
  logic signed [W-1:0] y_d;
  logic signed [W:0] err;

  always_comb begin
    err = {filtIn[W-1], filtIn} - {y_q[W-1], y_q};
    y_d = y_q;
    if (sampleTick) begin
      y_d = W'(($signed({y_q[W-1], y_q}) + (err >>> shiftAmt)));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      y_q <= '0;
    end else begin
      y_q <= y_d;
    end
  end

  assign filtOut = y_q;
endmodule
`default_nettype wire

// ==== testbench/slpf_assertions.sv ====
// checker for bus handshake and loop output timing
`default_nettype none
module slpf_assertions #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic sampleTick,
  input wire logic proportionalOnly,
  input wire slpf_pkg::slpf_ff_t ffOut,
  input wire logic signed [W-1:0] torqueRefOut
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_answer: assert property (s_req |=> s_ans)
    else $error("ack not one pulse one cycle after request");
  chk_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack outside a cycle");
  chk_ack_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved without request");
  chk_reset_pi: assert property ($rose(reset_n) |-> !proportionalOnly && torqueRefOut == 0 && ffOut == 0)
    else $error("outputs not cleared after reset");
  chk_po_holds: assert property (!sampleTick |=> $stable(proportionalOnly))
    else $error("regulator mode moved between samples");
  chk_ff_holds: assert property (!sampleTick |=> $stable(ffOut))
    else $error("feedforward moved between samples");
  chk_torque_holds: assert property (!sampleTick |=> $stable(torqueRefOut))
    else $error("torque reference moved between samples");
endmodule
bind slpf_core slpf_assertions #(.W(W)) slpf_assertions_i (.core_clk(core_clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sampleTick(sampleTick),
  .proportionalOnly(proportionalOnly), .ffOut(ffOut), .torqueRefOut(torqueRefOut));
`default_nettype wire

// ==== testbench/slpf_host_model.sv ====
// host side model: sample strobe, model-following and interpolation feedforward
`default_nettype none
module slpf_host_model #(
  parameter logic [31:0] MDL = 32'h0111_0022,
  parameter logic [31:0] CUB = 32'h0333_0044
) (
  input wire logic core_clk,
  input wire logic reset_n,
  output logic sampleTick,
  output slpf_pkg::slpf_ff_t modelFfIn,
  output slpf_pkg::slpf_ff_t cubicFfIn
);
  // ****
  // sample strobe every fourth cycle
  // ****
  logic [1:0] cnt_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
  assign sampleTick = (cnt_q == 2'h3);
  assign modelFfIn = MDL;
  assign cubicFfIn = CUB;
endmodule
`default_nettype wire

// ==== testbench/slpf_testbench.sv ====
// register and loop level testbench of the speed-loop selector
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] MDL = 32'h0111_0022;
  localparam logic [31:0] CUB = 32'h0333_0044;
  localparam logic [31:0] HST = 32'h0123_0045;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] datO;
  logic [31:0] rdat;
  logic ack;
  logic tick;
  logic po;
  logic signed [15:0] tOut;
  slpf_pkg::slpf_loop_t ld = '0;
  slpf_pkg::slpf_ff_t mdl;
  slpf_pkg::slpf_ff_t cub;
  slpf_pkg::slpf_ff_t ff;
  int mismatches = 0;
  int n_compared = 0;
  int k;
  logic [31:0] ctl [6] = '{32'h110, 32'h10110, 32'h220, 32'h100220, 32'h330, 32'h300330};
  logic [31:0] ex [6] = '{32'h0, MDL, 32'h0, HST, 32'h0, CUB};
  always #50 core_clk = ~core_clk;
  slpf_core slpf_core_i (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .sampleTick(tick),
    .loopIn(ld), .modelFfIn(mdl), .cubicFfIn(cub), .proportionalOnly(po), .ffOut(ff), .torqueRefOut(tOut));
  slpf_host_model #(.MDL(MDL), .CUB(CUB)) slpf_host_model_i (.core_clk(core_clk), .reset_n(reset_n),
    .sampleTick(tick), .modelFfIn(mdl), .cubicFfIn(cub));
  // ****
  // tasks
  // ****
  task close_out;
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      close_out();
    end
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wbw(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask
  task cfg(input logic [31:0] c);
    wbw(slpf_pkg::OFS_CTRL, c);
    wbw(slpf_pkg::OFS_CMD, 32'h1);
  endtask
  task nxt;
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge core_clk);
      if (tick === 1'b1) break;
    end
    if (i == 8) begin
      mismatches++;
      close_out();
    end
  endtask
  task tk(input int n);
    repeat (n) nxt();
    @(posedge core_clk);
  endtask
  task setq(input int m, input logic signed [15:0] v);
    case (m)
      1: ld.deviationCount <= v;
      2: ld.accelRef <= v;
      default: ld.speedRef <= v;
    endcase
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    rc("trqTh", slpf_pkg::OFS_TRQ_TH, 32'hc8);
    rc("inertia", slpf_pkg::OFS_INERTIA, 32'h64);
    rc("status", slpf_pkg::OFS_STATUS, 32'h0);
    rc("unmapped", 8'hf0, 32'h0);
    wbw(slpf_pkg::OFS_SFF_GAIN, 32'h32);
    wbw(slpf_pkg::OFS_TFF_GAIN, 32'h32);
    wbw(slpf_pkg::OFS_SFF_FILT, 32'h1);
    for (k = 0; k < 8; k++) begin
      nxt();
      ld.positionRef <= ld.positionRef + 16'sd10;
      ld.speedRef <= ld.speedRef + 16'sd20;
    end
    chk("speedFf", 32'(ff.speedFf), 32'h4);
    chk("torqueFf", 32'(ff.torqueFf), 32'ha);
    ld.torqueRefPct <= 16'sd201;
    ld.actualTorque <= 16'sd201;
    tk(2);
    chk("pOnly201", {31'h0, po}, 32'h1);
    ld.torqueRefPct <= 16'sd200;
    ld.actualTorque <= 16'sd200;
    tk(2);
    chk("pOnly200", {31'h0, po}, 32'h0);
    for (k = 1; k < 4; k++) begin
      cfg(32'(k));
      wbw(slpf_pkg::OFS_TRQ_TH + 8'(4 * k), 32'h32);
      setq(k, 16'sd51);
      tk(2);
      chk("pOnlyAbove", {31'h0, po}, 32'h1);
      setq(k, 16'sd50);
      tk(2);
      chk("pOnlyAt", {31'h0, po}, 32'h0);
    end
    ld.torqueRefPct <= 16'sd300;
    ld.actualTorque <= 16'sd300;
    ld.deviationCount <= 16'sd1000;
    ld.accelRef <= 16'sd1000;
    tk(2);
    chk("ownTh", {31'h0, po}, 32'h0);
    wbw(slpf_pkg::OFS_CTRL, 32'h4);
    setq(3, 16'sd1000);
    tk(2);
    chk("latched", {31'h0, po}, 32'h1);
    wbw(slpf_pkg::OFS_CMD, 32'h1);
    tk(2);
    chk("fixedPi", {31'h0, po}, 32'h0);
    cfg(32'h0);
    ld.torqueRefPct <= 16'sd100;
    ld.actualTorque <= 16'sd0;
    wbw(slpf_pkg::OFS_OBS_GAIN, 32'hf);
    wbw(slpf_pkg::OFS_LOAD_COMP, 32'h32);
    tk(4);
    chk("torqueOut", 32'(tOut), 32'h96);
    wbw(slpf_pkg::OFS_HOST_VEL, 32'h0123);
    wbw(slpf_pkg::OFS_HOST_TRQ, 32'h0045);
    for (k = 0; k < 6; k++) begin
      cfg(ctl[k]);
      tk(2);
      chk("ffSource", ff, ex[k]);
    end
    cfg(32'h2000);
    nxt();
    ld.positionRef <= ld.positionRef + 16'sd40;
    tk(2);
    chk("torqueFfHighSpeed", 32'(ff.torqueFf), 32'h14);
    close_out();
  end
endmodule
`default_nettype wire
